// ---- hw/ccpwm_top.sv ----
/*
 * Capture/compare/PWM mode control with period timer, two channels and
 * four steerable outputs on channel one.
 * Assumes a 16-bit capture/compare timer value on the same clock and
 * external port logic that owns pin direction.
 */
// Contract
// - Auto-shutdown registers exist only for channel one, never channel two.
// - PWM duty is ten bits: low-value byte high, control bits 5:4 low.
// - Outside PWM, configuration ignored; A is capture/compare, B-D port pins.
// - Single configuration modulates only A; B, C, D stay port pins.
// - Forward full bridge modulates D, holds A active, B and C inactive.
// - Half bridge modulates A and B with dead band; C, D port pins.
// - Reverse full bridge modulates B, holds C active, A and D inactive.
// - Mode 0000 switches the unit off and resets it; 0001 reserved.
// - Mode 0010 toggles the output pin on each compare match.
// - Modes 0011-0111 capture on selected edges with 1, 4, 16 prescale.
// - Mode 1000 drives pin low on entry, high on match, sets flag.
// - Mode 1001 drives pin high on entry, low on match, sets flag.
// - Mode 1010 only sets the flag on match; pin returns to port.
// - Mode 1011 pulses a timer reset event on match and sets flag.
// - PWM codes 11xx; bit 1 inverts A and C, bit 0 inverts B, D.
// - Dead-band delay and auto-shutdown control registers are provided.
// - On timer equal period: clear timer, set output unless zero, latch duty.
// - Output clears when buffered duty equals timer with two fine bits.
// - PWM control is double-buffered and loaded at each period start.
`timescale 1ns/10ps
`default_nettype none
module ccpwm_top
	import ccpwm_pkg::*;
(
	// Clock, reset, enable
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Register port
	input wire logic [REG_AW-1:0] addr_i,
	input wire logic [DW-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [DW-1:0] rdata_o,
	// Capture/compare timer and capture pin
	input wire logic [2*DW-1:0] cc_timer_i,
	input wire logic capture_pin_i,
	output logic special_event_o,
	output logic channel1_interrupt_flag_o,
	// Channel one outputs A..D in bits 0..3
	output logic [3:0] output_pin_o,
	output logic [3:0] output_pin_oe_o,
	// Channel two output
	output logic channel2_pin_o,
	output logic channel2_pin_oe_o
);
	ccpwm_state_t s_reg;
	ccpwm_state_t s_next;
	logic cap_level;
	logic [5:0] sub_last;
	logic [1:0] fine;
	logic tick;
	logic bnd;
	logic [3:0] md1;
	logic entry;
	logic hit;
	logic rise;
	logic fall;
	logic do_cap;
	logic set1;
	logic clr1;
	logic dbok;
	logic [3:0] act;
	logic [3:0] inv;
	logic [NCH-1:0] raw;

	function automatic logic is_pwm(input logic [3:0] m);
		return m[MODE_MSB:MODE_MSB-1] == PWM_SEL;
	endfunction

	function automatic logic cmp_drives(input logic [3:0] m);
		return m == M_CMP_TOG || m == M_CMP_SET || m == M_CMP_CLR;
	endfunction

	ccpwm_sync u_cap_sync (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.pin_i(capture_pin_i),
		.level_o(cap_level)
	);

	always_comb begin
		s_next = s_reg;
		unique case (s_reg.tctl[PS_MSB:PS_LSB])
			PS_DIV1: begin
				sub_last = SUB_LAST1;
				fine = s_reg.sub[1:0];
			end
			PS_DIV4: begin
				sub_last = SUB_LAST4;
				fine = s_reg.sub[3:2];
			end
			default: begin
				sub_last = SUB_LAST16;
				fine = s_reg.sub[5:4];
			end
		endcase
		tick = s_reg.tctl[TON_BIT] && (s_reg.sub == sub_last);
		bnd = tick && (s_reg.tmr == s_reg.per);
		md1 = s_reg.ctl[0][MODE_MSB:MODE_LSB];
		entry = md1 != s_reg.mprev;
		hit = (cc_timer_i == {s_reg.hi[0], s_reg.lo[0]}) && !s_reg.mhit;
		rise = cap_level && !s_reg.cap_prev;
		fall = !cap_level && s_reg.cap_prev;
		do_cap = 1'b0;
		set1 = 1'b0;
		clr1 = wr_i && (addr_i == A_STATUS) && wdata_i[FLAG1_BIT];
		// Mask the match clock itself so the high time equals the duty value
		for (int c = 0; c < NCH; c++) begin
			raw[c] = s_reg.pwm[c] && !(is_pwm(s_reg.mbuf[c]) && {s_reg.hi[c], s_reg.dlat[c]} == {s_reg.tmr, fine});
		end
		dbok = (raw[0] == s_reg.dbprev) && (s_reg.dbcnt == s_reg.dead[DB_MSB:0]);
		act = 4'h0;
		inv = 4'h0;
		if (ce_i) begin
			// Pulse and read data also hold while the enable is low
			s_next.spec = 1'b0;
			s_next.rdata = RST_BYTE;
			// Period timer
			if (s_reg.tctl[TON_BIT]) begin
				s_next.sub = (s_reg.sub == sub_last) ? 6'h00 : s_reg.sub + 6'h01;
			end
			if (tick) begin
				s_next.tmr = bnd ? RST_BYTE : s_reg.tmr + 8'h01;
			end
			// Duty and control buffering per channel
			for (int c = 0; c < NCH; c++) begin
				if (!is_pwm(s_reg.ctl[c][MODE_MSB:MODE_LSB])) begin
					s_next.mbuf[c] = s_reg.ctl[c][MODE_MSB:MODE_LSB];
					s_next.pwm[c] = 1'b0;
				end else if (bnd) begin
					// Loading only here keeps the outputs glitch free
					s_next.mbuf[c] = s_reg.ctl[c][MODE_MSB:MODE_LSB];
					s_next.hi[c] = s_reg.lo[c];
					s_next.dlat[c] = s_reg.ctl[c][DUTY_MSB:DUTY_LSB];
					s_next.pwm[c] = {s_reg.lo[c], s_reg.ctl[c][DUTY_MSB:DUTY_LSB]} != 10'h000;
				end else if (is_pwm(s_reg.mbuf[c]) && {s_reg.hi[c], s_reg.dlat[c]} == {s_reg.tmr, fine}) begin
					// A duty beyond the period never matches, so the output stays set
					s_next.pwm[c] = 1'b0;
				end
			end
			if (bnd && is_pwm(md1)) begin
				s_next.cbuf = s_reg.ctl[0][CFG_MSB:CFG_LSB];
			end
			// Channel one capture and compare
			s_next.mprev = md1;
			s_next.mhit = cc_timer_i == {s_reg.hi[0], s_reg.lo[0]};
			s_next.cap_prev = cap_level;
			if (entry) begin
				s_next.capcnt = 4'h0;
			end
			unique case (md1)
				M_OFF, M_RSVD: begin
					s_next.cmp_pin = 1'b0;
					s_next.capcnt = 4'h0;
				end
				M_CMP_TOG: begin
					if (hit) begin
						s_next.cmp_pin = !s_reg.cmp_pin;
					end
				end
				M_CAP_ANY: do_cap = rise || fall;
				M_CAP_FALL: do_cap = fall;
				M_CAP_RISE: do_cap = rise;
				M_CAP_R4, M_CAP_R16: begin
					if (rise && !entry) begin
						do_cap = s_reg.capcnt == ((md1 == M_CAP_R4) ? CAP_LAST4 : CAP_LAST16);
						s_next.capcnt = do_cap ? 4'h0 : s_reg.capcnt + 4'h1;
					end
				end
				M_CMP_SET: begin
					if (entry) begin
						s_next.cmp_pin = 1'b0;
					end else if (hit) begin
						s_next.cmp_pin = 1'b1;
						set1 = 1'b1;
					end
				end
				M_CMP_CLR: begin
					if (entry) begin
						s_next.cmp_pin = 1'b1;
					end else if (hit) begin
						s_next.cmp_pin = 1'b0;
						set1 = 1'b1;
					end
				end
				M_CMP_SW: set1 = hit;
				M_CMP_SPEC: begin
					s_next.spec = hit;
					set1 = hit;
				end
				default: begin
					s_next.capcnt = 4'h0;
				end
			endcase
			if (do_cap) begin
				s_next.hi[0] = cc_timer_i[2*DW-1:DW];
				s_next.lo[0] = cc_timer_i[DW-1:0];
				set1 = 1'b1;
			end
			// Set wins over a simultaneous clear
			s_next.flag1 = (s_reg.flag1 && !clr1) || set1;
			// Dead band restarts at every edge of the raw waveform
			s_next.dbprev = raw[0];
			if (raw[0] != s_reg.dbprev) begin
				s_next.dbcnt = '0;
			end else if (s_reg.dbcnt != s_reg.dead[DB_MSB:0]) begin
				s_next.dbcnt = s_reg.dbcnt + 7'h01;
			end
			// Output steering, bits are A, B, C, D from bit 0
			if (is_pwm(s_reg.mbuf[0])) begin
				inv = {s_reg.mbuf[0][0], s_reg.mbuf[0][1], s_reg.mbuf[0][0], s_reg.mbuf[0][1]};
				unique case (ccpwm_ocfg_t'(s_reg.cbuf))
					OC_SINGLE: begin
						act = {3'b000, raw[0]};
						s_next.pins.oe = 4'h1;
					end
					OC_FWD: begin
						act = {raw[0], 1'b0, 1'b0, 1'b1};
						s_next.pins.oe = 4'hf;
					end
					OC_HALF: begin
						act = {2'b00, !raw[0] && dbok, raw[0] && dbok};
						s_next.pins.oe = 4'h3;
					end
					OC_REV: begin
						act = {1'b0, 1'b1, raw[0], 1'b0};
						s_next.pins.oe = 4'hf;
					end
				endcase
				s_next.pins.out = (act ^ inv) & s_next.pins.oe;
			end else begin
				// Configuration bits are ignored here
				s_next.pins.oe = {3'b000, cmp_drives(md1)};
				s_next.pins.out = {3'b000, s_reg.cmp_pin && cmp_drives(md1)};
			end
			s_next.ch2_oe = is_pwm(s_reg.mbuf[1]);
			s_next.ch2_out = raw[1] && is_pwm(s_reg.mbuf[1]);
			// Register writes, after hardware updates so software wins
			if (wr_i) begin
				unique case (addr_i)
					A_TIMER_COUNT: s_next.tmr = wdata_i;
					A_PERIOD: s_next.per = wdata_i;
					A_TIMER_CTRL: s_next.tctl = wdata_i;
					A_CH1_LOW: s_next.lo[0] = wdata_i;
					A_CH1_HIGH: begin
						if (!is_pwm(md1)) begin
							s_next.hi[0] = wdata_i;
						end
					end
					A_CH1_CTRL: s_next.ctl[0] = wdata_i;
					A_CH2_LOW: s_next.lo[1] = wdata_i;
					A_CH2_HIGH: begin
						if (!is_pwm(s_reg.ctl[1][MODE_MSB:MODE_LSB])) begin
							s_next.hi[1] = wdata_i;
						end
					end
					A_CH2_CTRL: s_next.ctl[1] = wdata_i & CH2_CTRL_MASK;
					A_SHUTDOWN: s_next.shdn = wdata_i;
					A_DEAD_BAND: s_next.dead = wdata_i;
					default: ;
				endcase
			end
			if (rd_i) begin
				unique case (addr_i)
					A_TIMER_COUNT: s_next.rdata = s_reg.tmr;
					A_PERIOD: s_next.rdata = s_reg.per;
					A_TIMER_CTRL: s_next.rdata = s_reg.tctl;
					A_CH1_LOW: s_next.rdata = s_reg.lo[0];
					A_CH1_HIGH: s_next.rdata = s_reg.hi[0];
					A_CH1_CTRL: s_next.rdata = s_reg.ctl[0];
					A_CH2_LOW: s_next.rdata = s_reg.lo[1];
					A_CH2_HIGH: s_next.rdata = s_reg.hi[1];
					A_CH2_CTRL: s_next.rdata = s_reg.ctl[1];
					A_SHUTDOWN: s_next.rdata = s_reg.shdn;
					A_DEAD_BAND: s_next.rdata = s_reg.dead;
					A_STATUS: s_next.rdata = {7'h00, s_reg.flag1};
					default: s_next.rdata = RST_BYTE;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign rdata_o = s_reg.rdata;
	assign special_event_o = s_reg.spec;
	assign channel1_interrupt_flag_o = s_reg.flag1;
	assign output_pin_o = s_reg.pins.out;
	assign output_pin_oe_o = s_reg.pins.oe;
	assign channel2_pin_o = s_reg.ch2_out;
	assign channel2_pin_oe_o = s_reg.ch2_oe;

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_off_quiet: assert property (
		ce_i && md1 == M_OFF && s_reg.mbuf[0] == M_OFF |=> s_reg.pins.oe == 4'h0)
		else $error("Unit off but a pin is driven");
	a_cfg_ignored: assert property (
		ce_i && !is_pwm(s_reg.mbuf[0]) |=> s_reg.pins.oe[3:1] == 3'b000)
		else $error("Port pins taken outside PWM");
	a_single_pins: assert property (
		ce_i && is_pwm(s_reg.mbuf[0]) && s_reg.cbuf == OC_SINGLE
		|=> s_reg.pins.oe == 4'h1 && s_reg.pins.out[0] == ($past(raw[0]) ^ $past(s_reg.mbuf[0][1])))
		else $error("Single output wrong");
	a_fwd_levels: assert property (
		ce_i && is_pwm(s_reg.mbuf[0]) && s_reg.cbuf == OC_FWD
		|=> s_reg.pins.oe == 4'hf && s_reg.pins.out[0] != $past(s_reg.mbuf[0][1])
		&& s_reg.pins.out[1] == $past(s_reg.mbuf[0][0]) && s_reg.pins.out[2] == $past(s_reg.mbuf[0][1]))
		else $error("Forward bridge levels wrong");
	a_rev_levels: assert property (
		ce_i && is_pwm(s_reg.mbuf[0]) && s_reg.cbuf == OC_REV
		|=> s_reg.pins.oe == 4'hf && s_reg.pins.out[2] != $past(s_reg.mbuf[0][1])
		&& s_reg.pins.out[0] == $past(s_reg.mbuf[0][1]) && s_reg.pins.out[3] == $past(s_reg.mbuf[0][0]))
		else $error("Reverse bridge levels wrong");
	a_half_gap: assert property (
		ce_i && is_pwm(s_reg.mbuf[0]) && s_reg.cbuf == OC_HALF
		|=> s_reg.pins.oe == 4'h3 && !((s_reg.pins.out[0] ^ $past(s_reg.mbuf[0][1]))
		&& (s_reg.pins.out[1] ^ $past(s_reg.mbuf[0][0]))))
		else $error("Half bridge overlap");
	a_duty_latch: assert property (
		ce_i && bnd && is_pwm(md1)
		|=> s_reg.tmr == 8'h00 && s_reg.hi[0] == $past(s_reg.lo[0])
		&& s_reg.dlat[0] == $past(s_reg.ctl[0][DUTY_MSB:DUTY_LSB]))
		else $error("Duty not latched at period end");
	a_pwm_clear: assert property (
		ce_i && is_pwm(s_reg.mbuf[0]) && is_pwm(md1) && !bnd
		&& {s_reg.hi[0], s_reg.dlat[0]} == {s_reg.tmr, fine} |=> !s_reg.pwm[0])
		else $error("PWM not cleared on duty match");
	a_cfg_hold: assert property (
		ce_i && !bnd |=> $stable(s_reg.cbuf))
		else $error("Configuration loaded mid period");
	a_spec_flag: assert property (
		ce_i && md1 == M_CMP_SPEC && hit && !entry |=> s_reg.spec ##1 !s_reg.spec || s_reg.flag1)
		else $error("Special event missing");
	a_set_pin: assert property (
		ce_i && md1 == M_CMP_SET && !entry && hit |=> s_reg.cmp_pin && s_reg.flag1)
		else $error("Set on match failed");
endmodule
`default_nettype wire

// ---- hw/ccpwm_pkg.sv ----
/*
 * Constants, register map and state carriers of the capture/compare/PWM
 * mode control block.
 * Assumes one system clock; every file imports the whole package.
 */
package ccpwm_pkg;
	localparam int REG_AW = 4;
	localparam int DW = 8;
	localparam int NCH = 2;

	// Register indices on the plain register port
	localparam logic [REG_AW-1:0] A_TIMER_COUNT = 4'h0;
	localparam logic [REG_AW-1:0] A_PERIOD = 4'h1;
	localparam logic [REG_AW-1:0] A_TIMER_CTRL = 4'h2;
	localparam logic [REG_AW-1:0] A_CH1_LOW = 4'h3;
	localparam logic [REG_AW-1:0] A_CH1_HIGH = 4'h4;
	localparam logic [REG_AW-1:0] A_CH1_CTRL = 4'h5;
	localparam logic [REG_AW-1:0] A_CH2_LOW = 4'h6;
	localparam logic [REG_AW-1:0] A_CH2_HIGH = 4'h7;
	localparam logic [REG_AW-1:0] A_CH2_CTRL = 4'h8;
	localparam logic [REG_AW-1:0] A_SHUTDOWN = 4'h9;
	localparam logic [REG_AW-1:0] A_DEAD_BAND = 4'ha;
	localparam logic [REG_AW-1:0] A_STATUS = 4'hb;

	// Channel control fields
	localparam int CFG_MSB = 7;
	localparam int CFG_LSB = 6;
	localparam int DUTY_MSB = 5;
	localparam int DUTY_LSB = 4;
	localparam int MODE_MSB = 3;
	localparam int MODE_LSB = 0;
	localparam logic [DW-1:0] CH2_CTRL_MASK = 8'h3f;
	// Timer control, status flag and dead-band fields
	localparam int TON_BIT = 2;
	localparam int PS_MSB = 1;
	localparam int PS_LSB = 0;
	localparam int FLAG1_BIT = 0;
	localparam int DB_MSB = 6;

	localparam logic [DW-1:0] RST_BYTE = 8'h00;

	// Mode select codes
	localparam logic [3:0] M_OFF = 4'h0;
	localparam logic [3:0] M_RSVD = 4'h1;
	localparam logic [3:0] M_CMP_TOG = 4'h2;
	localparam logic [3:0] M_CAP_ANY = 4'h3;
	localparam logic [3:0] M_CAP_FALL = 4'h4;
	localparam logic [3:0] M_CAP_RISE = 4'h5;
	localparam logic [3:0] M_CAP_R4 = 4'h6;
	localparam logic [3:0] M_CAP_R16 = 4'h7;
	localparam logic [3:0] M_CMP_SET = 4'h8;
	localparam logic [3:0] M_CMP_CLR = 4'h9;
	localparam logic [3:0] M_CMP_SW = 4'ha;
	localparam logic [3:0] M_CMP_SPEC = 4'hb;
	localparam logic [1:0] PWM_SEL = 2'h3;

	typedef enum logic [1:0] {
		OC_SINGLE = 2'h0,
		OC_FWD = 2'h1,
		OC_HALF = 2'h2,
		OC_REV = 2'h3
	} ccpwm_ocfg_t;

	// Prescaler select and sub-counter limits (4 clock phases per tick)
	localparam logic [1:0] PS_DIV1 = 2'h0;
	localparam logic [1:0] PS_DIV4 = 2'h1;
	localparam logic [5:0] SUB_LAST1 = 6'h03;
	localparam logic [5:0] SUB_LAST4 = 6'h0f;
	localparam logic [5:0] SUB_LAST16 = 6'h3f;
	localparam logic [3:0] CAP_LAST4 = 4'h3;
	localparam logic [3:0] CAP_LAST16 = 4'hf;

	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
	} ccpwm_pins_t;

	typedef struct packed {
		logic [2:0] ff;
		logic filt;
	} ccpwm_sync_t;

	typedef struct packed {
		logic [DW-1:0] tmr;
		logic [DW-1:0] per;
		logic [DW-1:0] tctl;
		logic [DW-1:0] shdn;
		logic [DW-1:0] dead;
		logic [NCH-1:0][DW-1:0] lo;
		logic [NCH-1:0][DW-1:0] hi;
		logic [NCH-1:0][DW-1:0] ctl;
		logic [NCH-1:0][1:0] dlat;
		logic [NCH-1:0][3:0] mbuf;
		logic [NCH-1:0] pwm;
		logic [1:0] cbuf;
		logic [5:0] sub;
		logic [3:0] mprev;
		logic [3:0] capcnt;
		logic cap_prev;
		logic mhit;
		logic cmp_pin;
		logic flag1;
		logic spec;
		logic [DB_MSB:0] dbcnt;
		logic dbprev;
		ccpwm_pins_t pins;
		logic ch2_out;
		logic ch2_oe;
		logic [DW-1:0] rdata;
	} ccpwm_state_t;
endpackage

// ---- hw/ccpwm_sync.sv ----
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes the input is asynchronous to core_clk_i.
 */
`timescale 1ns/10ps
`default_nettype none
module ccpwm_sync
	import ccpwm_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Pin and filtered level
	input wire logic pin_i,
	output logic level_o
);
	ccpwm_sync_t s_reg;
	ccpwm_sync_t s_next;

	always_comb begin
		s_next = s_reg;
		if (ce_i) begin
			s_next.ff = {s_reg.ff[1:0], pin_i};
			// Only stages two and three vote, stage one stays isolated
			if (s_reg.ff[1] == s_reg.ff[2]) begin
				s_next.filt = s_reg.ff[2];
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign level_o = s_reg.filt;
endmodule
`default_nettype wire

// ---- sim/ccpwm_switch_model.sv ----
/*
 * Gate-driver model for the four steered outputs: counts the cycles each
 * switch is on inside a window and counts shoot-through on the A/B leg.
 * Assumes an undriven gate input is pulled low by the driver.
 */
`timescale 1ns/10ps
`default_nettype none
module ccpwm_switch_model
	import ccpwm_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Window control
	input wire logic clr_i,
	input wire logic en_i,
	// Pins and counts
	input wire ccpwm_pins_t pins_i,
	output logic [3:0][DW-1:0] on_cnt_o,
	output logic [DW-1:0] shoot_o
);
	logic [3:0] gate;

	// A released gate sits at the pull-down, never at the last level
	assign gate = pins_i.out & pins_i.oe;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			on_cnt_o <= '0;
			shoot_o <= '0;
		end else if (clr_i) begin
			on_cnt_o <= '0;
			shoot_o <= '0;
		end else if (en_i) begin
			for (int k = 0; k < 4; k++) begin
				on_cnt_o[k] <= on_cnt_o[k] + DW'(gate[k]);
			end
			// Both switches of one leg on together would short the supply
			shoot_o <= shoot_o + DW'(gate[0] & gate[1]);
		end
	end
endmodule
`default_nettype wire

// ---- sim/tb_ccpwm_top.sv ----
/*
 * Self-checking bench for the capture/compare/PWM mode control block.
 * Assumes the block's register map and timing from its package.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_ccpwm_top
	import ccpwm_pkg::*;
;
	logic core_clk_i, rst_n_i, ce_i, wr_i, rd_i, capture_pin_i;
	logic [REG_AW-1:0] addr_i;
	logic [DW-1:0] wdata_i, rdata_o;
	logic [2*DW-1:0] cc_timer_i;
	logic special_event_o, channel1_interrupt_flag_o, channel2_pin_o, channel2_pin_oe_o;
	logic [3:0] output_pin_o, output_pin_oe_o;
	ccpwm_pins_t pins;
	logic clr, en;
	logic [3:0][DW-1:0] cnt;
	logic [DW-1:0] shoot, ch2_on;
	int n_errors, tests_run, cyc, n_sev;
	// PWM table: control byte, on-cycles of A..D in 32 clocks, enables
	logic [7:0] t_ctl [6] = '{8'h2c, 8'h2e, 8'h6c, 8'h6f, 8'hec, 8'hee};
	logic [7:0] t_exp [6][4] = '{'{12, 0, 0, 0}, '{20, 0, 0, 0}, '{32, 0, 0, 12},
		'{0, 32, 32, 20}, '{0, 12, 32, 0}, '{32, 12, 0, 0}};
	logic [3:0] t_oe [6] = '{4'h1, 4'h1, 4'hf, 4'hf, 4'hf, 4'hf};
	logic v;

	assign pins = '{out: output_pin_o, oe: output_pin_oe_o};

	// Channel two has a single pin, so its on-time is counted beside the switch model
	always @(posedge core_clk_i) begin
		if (clr) begin
			ch2_on <= '0;
		end else if (en) begin
			ch2_on <= ch2_on + DW'(channel2_pin_o);
		end
	end

	ccpwm_top i_ccpwm_top (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cc_timer_i(cc_timer_i),
		.capture_pin_i(capture_pin_i), .special_event_o(special_event_o),
		.channel1_interrupt_flag_o(channel1_interrupt_flag_o), .output_pin_o(output_pin_o),
		.output_pin_oe_o(output_pin_oe_o), .channel2_pin_o(channel2_pin_o),
		.channel2_pin_oe_o(channel2_pin_oe_o));

	ccpwm_switch_model i_ccpwm_switch_model (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clr_i(clr),
		.en_i(en), .pins_i(pins), .on_cnt_o(cnt), .shoot_o(shoot));

	initial begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end

	task automatic tally_and_finish();
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Runaway guard well above the roughly one thousand cycles the tests need
	always @(posedge core_clk_i) begin
		cyc++;
		if (special_event_o === 1'b1) n_sev++;
		if (cyc == 40000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge core_clk_i);
		@(negedge core_clk_i);
	endtask

	task automatic wr(input logic [REG_AW-1:0] a, input logic [DW-1:0] d);
		@(posedge core_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [REG_AW-1:0] a, input logic [DW-1:0] exp);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		@(negedge core_clk_i);
		chk(rdata_o, exp);
	endtask

	task automatic flag_is(input logic f);
		chk({7'h0, channel1_interrupt_flag_o}, {7'h0, f});
	endtask

	task automatic clear_flag();
		wr(A_STATUS, 8'h01);
		idle(2);
		flag_is(1'b0);
	endtask

	// Mode change through off, compare value 0x1234 armed, timer away from it
	task automatic arm(input logic [DW-1:0] ctl);
		cc_timer_i <= 16'h0000;
		wr(A_CH1_CTRL, 8'h00);
		idle(2);
		chk({4'h0, output_pin_oe_o}, 8'h00);
		wr(A_CH1_HIGH, 8'h12);
		wr(A_CH1_LOW, 8'h34);
		wr(A_CH1_CTRL, ctl);
		idle(4);
	endtask

	task automatic hit();
		@(posedge core_clk_i);
		cc_timer_i <= 16'h1234;
		idle(4);
		cc_timer_i <= 16'h0000;
	endtask

	task automatic cmp_case(input logic [3:0] m, input logic [3:0] oe, input logic ent, input logic aft);
		arm({4'hc, m});
		chk({4'h0, output_pin_oe_o}, {4'h0, oe});
		chk({7'h0, output_pin_o[0]}, {7'h0, ent});
		hit();
		chk({7'h0, output_pin_o[0]}, {7'h0, aft});
		flag_is(1'b1);
		clear_flag();
	endtask

	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge core_clk_i);
			capture_pin_i <= 1'b1;
			idle(6);
			capture_pin_i <= 1'b0;
			idle(6);
		end
	endtask

	task automatic win();
		@(posedge core_clk_i);
		clr <= 1'b1;
		@(posedge core_clk_i);
		clr <= 1'b0;
		en <= 1'b1;
		repeat (32) @(posedge core_clk_i);
		en <= 1'b0;
		idle(1);
	endtask

	initial begin
		rst_n_i = 1'b0;
		ce_i = 1'b1;
		wr_i = 1'b0;
		rd_i = 1'b0;
		capture_pin_i = 1'b0;
		addr_i = '0;
		wdata_i = '0;
		cc_timer_i = '0;
		clr = 1'b0;
		en = 1'b0;
		repeat (3) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		rd(A_CH1_CTRL, 8'h00);
		rd(4'hc, 8'h00);
		wr(A_DEAD_BAND, 8'h7f);
		rd(A_DEAD_BAND, 8'h7f);
		wr(A_SHUTDOWN, 8'h5a);
		rd(A_SHUTDOWN, 8'h5a);
		wr(A_SHUTDOWN, 8'h00);
		wr(A_DEAD_BAND, 8'h00);
		wr(A_CH2_CTRL, 8'hff);
		rd(A_CH2_CTRL, 8'h3f);
		wr(A_CH2_CTRL, 8'h00);
		cmp_case(M_CMP_SET, 4'h1, 1'b0, 1'b1);
		cmp_case(M_CMP_CLR, 4'h1, 1'b1, 1'b0);
		cmp_case(M_CMP_SW, 4'h0, 1'b0, 1'b0);
		cmp_case(M_CMP_SPEC, 4'h0, 1'b0, 1'b0);
		chk(DW'(n_sev), 8'h01);
		arm({4'h0, M_CMP_TOG});
		v = output_pin_o[0];
		hit();
		chk({7'h0, output_pin_o[0]}, {7'h0, ~v});
		hit();
		chk({7'h0, output_pin_o[0]}, {7'h0, v});
		cc_timer_i <= 16'h5a3c;
		wr(A_CH1_CTRL, {4'h0, M_CAP_RISE});
		idle(4);
		pulse(1);
		rd(A_CH1_HIGH, 8'h5a);
		rd(A_CH1_LOW, 8'h3c);
		flag_is(1'b1);
		clear_flag();
		arm({4'h0, M_CAP_FALL});
		capture_pin_i <= 1'b1;
		idle(8);
		flag_is(1'b0);
		capture_pin_i <= 1'b0;
		idle(8);
		flag_is(1'b1);
		clear_flag();
		arm({4'h0, M_CAP_R4});
		pulse(3);
		flag_is(1'b0);
		pulse(1);
		flag_is(1'b1);
		clear_flag();
		// Software order: period, duty, timer, then mode; pin direction lives outside
		wr(A_CH1_CTRL, 8'h00);
		wr(A_PERIOD, 8'h03);
		wr(A_CH1_LOW, 8'h01);
		wr(A_TIMER_CTRL, 8'h04);
		for (int i = 0; i < 6; i++) begin
			wr(A_CH1_CTRL, t_ctl[i]);
			idle(40);
			win();
			for (int k = 0; k < 4; k++) begin
				chk(cnt[k], t_exp[i][k]);
			end
			chk({4'h0, output_pin_oe_o}, {4'h0, t_oe[i]});
		end
		wr(A_CH1_HIGH, 8'h77);
		rd(A_CH1_HIGH, 8'h01);
		wr(A_CH1_CTRL, 8'hac);
		idle(40);
		win();
		chk({4'h0, output_pin_oe_o}, 8'h03);
		chk(shoot, 8'h00);
		chk({7'h0, cnt[0] != 0 && cnt[0] <= 12}, 8'h01);
		chk({7'h0, cnt[1] != 0 && cnt[1] <= 20}, 8'h01);
		wr(A_CH1_LOW, 8'h10);
		wr(A_CH1_CTRL, 8'h0c);
		idle(40);
		win();
		chk(cnt[0], 8'd32);
		wr(A_CH1_LOW, 8'h00);
		idle(40);
		win();
		chk(cnt[0], 8'd0);
		// A write while the enable is low must not land
		ce_i <= 1'b0;
		wr(A_PERIOD, 8'h09);
		ce_i <= 1'b1;
		rd(A_PERIOD, 8'h03);
		wr(A_CH2_LOW, 8'h01);
		wr(A_CH2_CTRL, 8'h2c);
		idle(40);
		chk({7'h0, channel2_pin_oe_o}, 8'h01);
		win();
		chk(ch2_on, 8'd12);
		tally_and_finish();
	end
endmodule
`default_nettype wire
